// *** dv/tb.sv ***
// Self-checking testbench for the dual reload/capture timer.
// Assumes the design, package, checker and pin model are compiled before it.
`timescale 1ns/1ps
module tb;
    logic                     core_clk;
    logic                     rst;
    logic [7:0]               reg_addr;
    logic [15:0]              reg_wdata;
    logic                     reg_wr;
    logic                     reg_rd;
    logic [15:0]              reg_rdata;
    trc_pkg::trc_pins_t [1:0] timer_pins;
    logic                     irq;
    logic [15:0]              v;
    logic [15:0]              w;
    logic [7:0]               addrs [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h30};
    int                       error_cnt;
    int                       cmp_count;

    trc_timer u_dut (
        .core_clk   (core_clk),
        .rst        (rst),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .timer_pins (timer_pins),
        .irq        (irq)
    );
    trc_pin_model u_pins (
        .core_clk   (core_clk),
        .timer_pins (timer_pins)
    );

    // Clock of 25 ns period.
    always #12.5 core_clk = ~core_clk;

    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // One-cycle register read; data taken in the cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Exact comparison.
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk

    // Range comparison for values that depend on the tick phase.
    task automatic chk_rng(input string nm, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, got);
            error_cnt++;
        end
    endtask : chk_rng

    // Bounded wait for the interrupt line.
    task automatic wait_irq(input int n);
        int i;
        for (i = 0; i < n && irq !== 1'b1; i++)
            @(posedge core_clk);
        chk("irq_wait", 16'h0001, {15'h0000, irq});
        if (irq !== 1'b1)
            tally_and_finish();
    endtask : wait_irq

    // Report the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Main sequence.
    initial
    begin
        core_clk  = 1'b0;
        rst       = 1'b1;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        wr(8'h30, 16'h5a5a);
        foreach (addrs[i])
        begin
            rd(addrs[i], v);
            chk("reset_value", 16'h0000, v);
        end
        // Tick rate without and with the prescaler.
        wr(8'h00, 16'h0001);
        rd(8'h08, v);
        repeat (118) @(posedge core_clk);
        rd(8'h08, w);
        chk("tick_div12", 16'h000a, w - v);
        wr(8'h00, 16'h0101);
        rd(8'h08, v);
        repeat (238) @(posedge core_clk);
        rd(8'h08, w);
        chk("tick_div24", 16'h000a, w - v);
        // Overflow reload with interrupt, masking and clearing.
        wr(8'h00, 16'h0000);
        wr(8'h04, 16'hfff0);
        wr(8'h08, 16'hfffe);
        wr(8'h24, 16'h000f);
        wr(8'h00, 16'h0001);
        wait_irq(60);
        rd(8'h08, v);
        chk_rng("ovf_reload", 16'hfff0, 16'hfff1, v);
        rd(8'h20, v);
        chk("ovf_status", 16'h0001, v);
        wr(8'h24, 16'h0000);
        #1;
        chk("irq_masked", 16'h0000, {15'h0000, irq});
        wr(8'h20, 16'h0001);
        wr(8'h24, 16'h000f);
        rd(8'h20, v);
        chk("status_clear", 16'h0000, v);
        // Reload on a falling trigger edge.
        wr(8'h04, 16'h1234);
        wr(8'h08, 16'h0100);
        wr(8'h00, 16'h0011);
        u_pins.set_trig(0, 1'b0);
        repeat (8) @(posedge core_clk);
        rd(8'h08, v);
        chk_rng("trig_reload", 16'h1234, 16'h1235, v);
        rd(8'h20, v);
        chk("trig_status", 16'h0001, v);
        // Up/down: trigger low counts down and reloads FFFF at the stored value.
        wr(8'h00, 16'h0008);
        wr(8'h20, 16'h000f);
        wr(8'h04, 16'h0010);
        wr(8'h08, 16'h0012);
        wr(8'h00, 16'h0009);
        repeat (60) @(posedge core_clk);
        rd(8'h08, v);
        chk_rng("down_reload", 16'hfffa, 16'hffff, v);
        // Trigger high counts up and reloads the stored value past FFFF.
        wr(8'h00, 16'h0008);
        wr(8'h04, 16'h0500);
        wr(8'h08, 16'hfffe);
        u_pins.set_trig(0, 1'b1);
        wr(8'h00, 16'h0009);
        repeat (60) @(posedge core_clk);
        rd(8'h08, v);
        chk_rng("up_reload", 16'h0500, 16'h0504, v);
        rd(8'h20, v);
        chk("updown_status", 16'h0000, v);
        // Capture mode on timer 1: wrap to zero, then capture on a rising edge only.
        wr(8'h00, 16'h0000);
        wr(8'h18, 16'hfffe);
        wr(8'h10, 16'h0035);
        wait_irq(60);
        rd(8'h18, v);
        chk_rng("cap_wrap", 16'h0000, 16'h0002, v);
        rd(8'h20, v);
        chk("wrap_status", 16'h0004, v);
        wr(8'h20, 16'h0004);
        u_pins.set_trig(1, 1'b0);
        repeat (8) @(posedge core_clk);
        rd(8'h20, v);
        chk("fall_ignored", 16'h0000, v);
        u_pins.set_trig(1, 1'b1);
        repeat (8) @(posedge core_clk);
        rd(8'h14, w);
        chk_rng("cap_value", 16'h0001, 16'h0002, w);
        rd(8'h18, v);
        chk_rng("cap_count", w, w + 16'h0002, v);
        rd(8'h20, v);
        chk("cap_status", 16'h0008, v);
        // Counter mode on timer 1 counts count-pin falling edges.
        wr(8'h10, 16'h0002);
        wr(8'h18, 16'h0000);
        wr(8'h10, 16'h0003);
        u_pins.pulse(1, 5);
        repeat (30) @(posedge core_clk);
        rd(8'h18, v);
        chk("pin_count", 16'h0005, v);
        tally_and_finish();
    end
endmodule : tb

// *** dv/trc_pin_model.sv ***
// Model of the external count and trigger pins of both timers.
// Assumes the testbench calls its tasks; pins move just after a rising clock edge.
`timescale 1ns/1ps
module trc_pin_model (
    // Clock.
    input wire logic                 core_clk,
    // Pins toward the timers.
    output trc_pkg::trc_pins_t [1:0] timer_pins
);
    // Both pins of both timers idle high.
    initial
    begin
        timer_pins = 4'hf;
    end

    // Set the trigger level of one timer.
    task automatic set_trig(input int idx, input logic lvl);
        @(posedge core_clk);
        timer_pins[idx].reload_capture_trigger_pin <= lvl;
    endtask : set_trig

    // Falling edges on the count pin, 13 clocks low and high so each level spans a tick.
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            timer_pins[idx].external_count_pin <= 1'b0;
            repeat (13) @(posedge core_clk);
            timer_pins[idx].external_count_pin <= 1'b1;
            repeat (12) @(posedge core_clk);
        end
    endtask : pulse
endmodule : trc_pin_model

// *** dv/trc_timer_asserts.sv ***
// Checker for the dual reload/capture timer, bound to the top module.
// Assumes it sees only the top-level ports; shadows of software writes are kept here.
`timescale 1ns/1ps
module trc_timer_chk (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        rst,
    // Register port.
    input wire logic [7:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Interrupt request.
    input wire logic        irq
);
    logic [15:0] ctrl0_q;
    logic [15:0] ctrl1_q;
    logic [15:0] cnt0_q;
    logic [3:0]  mask_q;
    logic        hold0_q;
    logic        ev_ok;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Shadow what software wrote; the count of timer 0 is trusted only while it stays stopped.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ctrl0_q <= 16'h0000;
            ctrl1_q <= 16'h0000;
            cnt0_q  <= 16'h0000;
            mask_q  <= 4'h0;
            hold0_q <= 1'b1;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                8'h00: ctrl0_q <= reg_wdata;
                8'h10: ctrl1_q <= reg_wdata;
                8'h08: cnt0_q <= reg_wdata;
                8'h24: mask_q <= reg_wdata[3:0];
                default: ;
            endcase
            if (reg_addr == 8'h08 && !ctrl0_q[0])
                hold0_q <= 1'b1;
            else if (reg_addr == 8'h00 && reg_wdata[0])
                hold0_q <= 1'b0;
        end
    end

    // A timer able to raise an event runs outside the up/down variant.
    assign ev_ok = (ctrl0_q[0] & (ctrl0_q[2] | ~ctrl0_q[3])) | (ctrl1_q[0] & (ctrl1_q[2] | ~ctrl1_q[3]));

    rst_quiet_a: assert property (disable iff (1'b0) $fell(rst) |-> !irq && reg_rdata == 16'h0000)
        else $error("outputs not quiet after reset");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its read cycle");
    unmapped_zero_a: assert property (reg_rd && (reg_addr == 8'h0c || reg_addr == 8'h30) |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    ctrl_back_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == ctrl0_q)
        else $error("control read back wrong");
    mask_back_a: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata[3:0] == mask_q)
        else $error("mask read back wrong");
    irq_masked_a: assert property (irq |-> mask_q != 4'h0)
        else $error("interrupt with all sources masked");
    count_hold_a: assert property (reg_rd && reg_addr == 8'h08 && hold0_q |=> reg_rdata == cnt0_q)
        else $error("stopped count moved");
    updown_quiet_a: assert property ($rose(irq) && !$past(reg_wr) |-> $past(ev_ok) || $past(ev_ok, 2))
        else $error("interrupt without a timer able to raise it");
endmodule : trc_timer_chk

bind trc_timer trc_timer_chk u_chk (
    .core_clk  (core_clk),
    .rst       (rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .irq       (irq)
);

// *** rtl/trc_defs.svh ***
// Constants for the dual 16-bit reload/capture timer: register offsets, field positions,
// reset values and clock divider counts.
// Assumes it is included by bare name after the package, by the timer design files only.
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH

// Register offsets on the byte-addressed register port.
`define TRC_INST_STRIDE     8'h10
`define TRC_OFS_CTRL        4'h0
`define TRC_OFS_RELOAD      4'h4
`define TRC_OFS_COUNT       4'h8
`define TRC_ADDR_IRQ_STATUS 8'h20
`define TRC_ADDR_IRQ_MASK   8'h24

// Control register field positions.
`define TRC_CTRL_RUN        0
`define TRC_CTRL_COUNTER    1
`define TRC_CTRL_CAPTURE    2
`define TRC_CTRL_UPDOWN     3
`define TRC_CTRL_TRIG_EN    4
`define TRC_CTRL_RISING     5
`define TRC_CTRL_PRESC_LSB  8
`define TRC_CTRL_PRESC_MSB  10

// Interrupt status bit positions within one timer's pair of bits.
`define TRC_IRQ_RELOAD_BIT  0
`define TRC_IRQ_CAPTURE_BIT 1

// Reset values.
`define TRC_CTRL_RESET      16'h0000
`define TRC_COUNT_RESET     16'h0000
`define TRC_RELOAD_RESET    16'h0000
`define TRC_MASK_RESET      4'h0

// Count limits.
`define TRC_COUNT_MAX       16'hffff
`define TRC_COUNT_MIN       16'h0000

// Peripheral clocks per count tick with the prescaler off.
`define TRC_BASE_DIV        4'hc

`endif

// *** rtl/trc_pkg.sv ***
// Types shared by the dual 16-bit reload/capture timer.
// Assumes nothing of its surroundings; users name every item as trc_pkg::name.
package trc_pkg;

    // Pins of one timer instance.
    typedef struct packed {
        logic external_count_pin;
        logic reload_capture_trigger_pin;
    } trc_pins_t;

    // Control register layout of one timer instance.
    typedef struct packed {
        logic [4:0] unused_hi;
        logic [2:0] presc;
        logic [1:0] unused_mid;
        logic       rising;
        logic       trig_en;
        logic       updown;
        logic       capture;
        logic       counter;
        logic       run;
    } trc_ctrl_t;

    // Operating mode derived from the control bits.
    typedef enum logic [1:0] {
        TRC_MODE_RELOAD,
        TRC_MODE_UPDOWN,
        TRC_MODE_CAPTURE
    } trc_mode_t;

endpackage : trc_pkg

// *** rtl/trc_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes the inputs are plain levels; only the second stage is used outside.
`timescale 1ns/1ps
module trc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Pin levels in and synchronised levels out.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] stage1_q;

    // The first stage feeds only the second stage; reset preloads both stages with the
    // pin level, so the release of reset shows no false edge downstream.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stage1_q <= pin_in;
            pin_sync <= pin_in;
        end
        else
        begin
            stage1_q <= pin_in;
            pin_sync <= stage1_q;
        end
    end

endmodule : trc_sync

// *** rtl/trc_timer.sv ***
// Two identical 16-bit timer/counters with auto-reload, up/down and one-channel capture
// modes, a shared register port and one level interrupt.
// Assumes one 40 MHz clock core_clk, synchronous active-high rst, and a register master
// that issues one-cycle strobes and takes read data in the cycle after the read strobe.
//
// How it works
// - Two identical 16-bit timers, reload or capture.
// - Timer mode ticks every twelve peripheral clocks, times 2**presc.
// - Counter mode counts count-pin falling edges, slow.
// - Reload mode counts up from reload value.
// - Reload on overflow, optionally also trigger edge.
// - Each reload loads stored value, raises interrupt.
// - Up/down: trigger level picks direction, no interrupt.
// - Counting up reloads stored value on overflow.
// - Counting down underflows at stored value, reloads FFFF.
// - Capture mode counts up, wraps to zero.
// - Trigger edge copies count into stored value.
// - Capture mode interrupts on reload and capture.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "trc_defs.svh"
module trc_timer (
    // Clock and reset.
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // Register port.
    input  wire logic [7:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [15:0]              reg_rdata,
    // Timer pins, one entry per timer.
    input  wire trc_pkg::trc_pins_t [1:0] timer_pins,
    // Interrupt request.
    output logic                          irq
);

    localparam int NUM_TMR = 2;

    logic [3:0]               base_cnt_q;
    logic                     base_tick;
    logic [3:0]               pins_raw;
    logic [3:0]               pins_sync;
    trc_pkg::trc_ctrl_t       ctrl_q [NUM_TMR];
    logic [15:0]              reload_capture_value_q [NUM_TMR];
    logic [15:0]              timer_count_value_q [NUM_TMR];
    logic [15:0]              count_d [NUM_TMR];
    logic [6:0]               presc_cnt_q [NUM_TMR];
    logic                     count_smp_q [NUM_TMR];
    logic                     trig_prev_q [NUM_TMR];
    logic                     tick [NUM_TMR];
    logic                     advance [NUM_TMR];
    logic                     trig_edge [NUM_TMR];
    logic                     reload_ev [NUM_TMR];
    logic                     capture_ev [NUM_TMR];
    logic                     wr_ctrl [NUM_TMR];
    logic                     wr_reload [NUM_TMR];
    logic                     wr_count [NUM_TMR];
    trc_pkg::trc_mode_t       mode [NUM_TMR];
    logic [3:0]               irq_status_q;
    logic [3:0]               irq_mask_q;
    logic [3:0]               irq_set;
    logic                     wr_status;
    logic                     wr_mask;

    // Base divider: one pulse every twelve peripheral clocks feeds both prescalers.
    always_ff @(posedge core_clk)
    begin
        if (rst || base_tick)
        begin
            base_cnt_q <= 4'h0;
        end
        else
        begin
            base_cnt_q <= base_cnt_q + 4'h1;
        end
    end

    assign base_tick = (base_cnt_q == (`TRC_BASE_DIV - 4'h1));

    // Both timers' pins pass one shared synchroniser.
    always_comb
    begin
        for (int k = 0; k < NUM_TMR; k++)
        begin
            pins_raw[2*k]   = timer_pins[k].external_count_pin;
            pins_raw[2*k+1] = timer_pins[k].reload_capture_trigger_pin;
        end
    end

    trc_sync #(
        .WIDTH    (4)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (pins_raw),
        .pin_sync (pins_sync)
    );

    // Global register write decodes.
    assign wr_status = reg_wr && (reg_addr == `TRC_ADDR_IRQ_STATUS);
    assign wr_mask   = reg_wr && (reg_addr == `TRC_ADDR_IRQ_MASK);

    generate
        for (genvar i = 0; i < NUM_TMR; i++)
        begin : g_tmr
            // Per-timer register write decodes.
            assign wr_ctrl[i]   = reg_wr && (reg_addr == 8'((i * 16) + `TRC_OFS_CTRL));
            assign wr_reload[i] = reg_wr && (reg_addr == 8'((i * 16) + `TRC_OFS_RELOAD));
            assign wr_count[i]  = reg_wr && (reg_addr == 8'((i * 16) + `TRC_OFS_COUNT));

            // Mode selection from the control bits; capture takes precedence over up/down.
            assign mode[i] = ctrl_q[i].capture ? trc_pkg::TRC_MODE_CAPTURE :
                             (ctrl_q[i].updown ? trc_pkg::TRC_MODE_UPDOWN : trc_pkg::TRC_MODE_RELOAD);

            // Control register.
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    ctrl_q[i] <= `TRC_CTRL_RESET;
                end
                else if (wr_ctrl[i])
                begin
                    ctrl_q[i] <= reg_wdata;
                end
            end

            // Prescaler: passes one base pulse in every 2**presc.
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    presc_cnt_q[i] <= 7'h00;
                end
                else if (!ctrl_q[i].run || tick[i])
                begin
                    presc_cnt_q[i] <= 7'h00;
                end
                else if (base_tick)
                begin
                    presc_cnt_q[i] <= presc_cnt_q[i] + 7'h01;
                end
            end

            assign tick[i] = base_tick && (presc_cnt_q[i] == 7'((8'h01 << ctrl_q[i].presc) - 8'h01));

            // Count pin is sampled once per tick, so a falling edge needs one tick high
            // and one tick low: the fastest countable rate is a 24-clock period.
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    count_smp_q[i] <= 1'b0;
                end
                else if (tick[i])
                begin
                    count_smp_q[i] <= pins_sync[2*i];
                end
            end

            // Trigger pin previous level; it tracks the pin through reset, so no false edge follows it.
            always_ff @(posedge core_clk)
            begin
                trig_prev_q[i] <= pins_sync[2*i+1];
            end

            // Advance on a tick in timer mode, on a sampled falling edge in counter mode.
            assign advance[i] = ctrl_q[i].run && tick[i] &&
                                (!ctrl_q[i].counter || (count_smp_q[i] && !pins_sync[2*i]));

            // Selected trigger edge, only while enabled and running.
            assign trig_edge[i] = ctrl_q[i].run && ctrl_q[i].trig_en &&
                                  (ctrl_q[i].rising ? (pins_sync[2*i+1] && !trig_prev_q[i])
                                                    : (!pins_sync[2*i+1] && trig_prev_q[i]));

            // Capture event copies the count in capture mode.
            assign capture_ev[i] = trig_edge[i] && (mode[i] == trc_pkg::TRC_MODE_CAPTURE);

            // Next count value and reload event for each mode.
            always_comb
            begin
                count_d[i]   = timer_count_value_q[i];
                reload_ev[i] = 1'b0;
                case (mode[i])
                    trc_pkg::TRC_MODE_RELOAD:
                    begin
                        if (trig_edge[i])
                        begin
                            count_d[i]   = reload_capture_value_q[i];
                            reload_ev[i] = 1'b1;
                        end
                        else if (advance[i])
                        begin
                            if (timer_count_value_q[i] == `TRC_COUNT_MAX)
                            begin
                                count_d[i]   = reload_capture_value_q[i];
                                reload_ev[i] = 1'b1;
                            end
                            else
                            begin
                                count_d[i] = timer_count_value_q[i] + 16'h0001;
                            end
                        end
                    end
                    trc_pkg::TRC_MODE_UPDOWN:
                    begin
                        // Trigger level high counts up, low counts down; never interrupts.
                        if (advance[i] && pins_sync[2*i+1])
                        begin
                            if (timer_count_value_q[i] == `TRC_COUNT_MAX)
                            begin
                                count_d[i] = reload_capture_value_q[i];
                            end
                            else
                            begin
                                count_d[i] = timer_count_value_q[i] + 16'h0001;
                            end
                        end
                        else if (advance[i])
                        begin
                            if (timer_count_value_q[i] == reload_capture_value_q[i])
                            begin
                                count_d[i] = `TRC_COUNT_MAX;
                            end
                            else
                            begin
                                count_d[i] = timer_count_value_q[i] - 16'h0001;
                            end
                        end
                    end
                    default:
                    begin
                        if (advance[i])
                        begin
                            if (timer_count_value_q[i] == `TRC_COUNT_MAX)
                            begin
                                count_d[i]   = `TRC_COUNT_MIN;
                                reload_ev[i] = 1'b1;
                            end
                            else
                            begin
                                count_d[i] = timer_count_value_q[i] + 16'h0001;
                            end
                        end
                    end
                endcase
                if (wr_count[i])
                begin
                    count_d[i] = reg_wdata;
                end
            end

            // Count register; a software write overrides the hardware step.
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    timer_count_value_q[i] <= `TRC_COUNT_RESET;
                end
                else
                begin
                    timer_count_value_q[i] <= count_d[i];
                end
            end

            // Reload/capture register; a capture wins over a software write.
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    reload_capture_value_q[i] <= `TRC_RELOAD_RESET;
                end
                else if (capture_ev[i])
                begin
                    reload_capture_value_q[i] <= timer_count_value_q[i];
                end
                else if (wr_reload[i])
                begin
                    reload_capture_value_q[i] <= reg_wdata;
                end
            end

            // Interrupt events of this timer; up/down mode raises none.
            assign irq_set[2*i+`TRC_IRQ_RELOAD_BIT]  = reload_ev[i] &&
                                                       (mode[i] != trc_pkg::TRC_MODE_UPDOWN);
            assign irq_set[2*i+`TRC_IRQ_CAPTURE_BIT] = capture_ev[i];
        end
    endgenerate

    // Sticky status, cleared by writing one; a new event in the clearing cycle survives.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_status_q <= 4'h0;
        end
        else if (wr_status)
        begin
            irq_status_q <= (irq_status_q & ~reg_wdata[3:0]) | irq_set;
        end
        else
        begin
            irq_status_q <= irq_status_q | irq_set;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_mask_q <= `TRC_MASK_RESET;
        end
        else if (wr_mask)
        begin
            irq_mask_q <= reg_wdata[3:0];
        end
    end

    // Level interrupt while any unmasked status bit is set.
    assign irq = |(irq_status_q & irq_mask_q);

    // Read data, registered, valid in the cycle after the read strobe only.
    always_ff @(posedge core_clk)
    begin
        if (rst || !reg_rd)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_addr == `TRC_ADDR_IRQ_STATUS)
        begin
            reg_rdata <= {12'h000, irq_status_q};
        end
        else if (reg_addr == `TRC_ADDR_IRQ_MASK)
        begin
            reg_rdata <= {12'h000, irq_mask_q};
        end
        else if ((reg_addr[7:5] == 3'h0) && (reg_addr[3:0] == `TRC_OFS_CTRL))
        begin
            reg_rdata <= ctrl_q[reg_addr[4]];
        end
        else if ((reg_addr[7:5] == 3'h0) && (reg_addr[3:0] == `TRC_OFS_RELOAD))
        begin
            reg_rdata <= reload_capture_value_q[reg_addr[4]];
        end
        else if ((reg_addr[7:5] == 3'h0) && (reg_addr[3:0] == `TRC_OFS_COUNT))
        begin
            reg_rdata <= timer_count_value_q[reg_addr[4]];
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule : trc_timer
